/* shared/dsu_map.svh */
// Register offsets, field positions and timing constants of the dual serial port block
`ifndef DSU_MAP_SVH
`define DSU_MAP_SVH
// Byte offsets on the AHB-Lite slave
`define DSU_OFF_SCON0 12'h000
`define DSU_OFF_SBUF0 12'h004
`define DSU_OFF_SCON1 12'h008
`define DSU_OFF_SBUF1 12'h00C
`define DSU_OFF_TIMER2_CONTROL 12'h010
`define DSU_OFF_POWER_CONTROL_REG 12'h014
`define DSU_OFF_T1REL 12'h018
`define DSU_OFF_T2REL 12'h01C
// Serial control fields
`define DSU_SC_MODE_HI 7
`define DSU_SC_MODE_LO 6
`define DSU_SC_MPF 5
`define DSU_SC_REN 4
`define DSU_SC_TB8 3
`define DSU_SC_RB8 2
`define DSU_SC_TI 1
`define DSU_SC_RI 0
// Timer 2 control fields
`define DSU_T2_TF2 7
`define DSU_T2_EXF2 6
`define DSU_T2_RCLK 5
`define DSU_T2_TX_CLOCK_SELECT 4
`define DSU_T2_EXEN 3
`define DSU_T2_TR2 2
`define DSU_T2_CPRL 0
// Power control fields
`define DSU_PC_SMOD 7
`define DSU_PC_PORT2_RX_CLOCK_SELECT 5
`define DSU_PC_PORT2_TX_CLOCK_SELECT 4
// Prescale counts in oscillator clocks; shift count is half a bit time
`define DSU_DIV_SHIFT 4'h5
`define DSU_DIV_MACHINE 4'hB
`define DSU_DIV_FIX 6'h1F
`define DSU_DIV_FIX_FAST 6'h0F
// Oversample count per bit
`define DSU_OVS_LAST 4'hF
`define DSU_OVS_MID 4'h7
`define DSU_OVS_HALF 4'h7
`endif

/* shared/dsu_pkg.sv */
// Types shared by the dual serial port block
package dsu_pkg;
	typedef enum logic [1:0] {
		DSU_MODE_SHIFT = 2'b00,
		DSU_MODE_VAR8 = 2'b01,
		DSU_MODE_FIX9 = 2'b10,
		DSU_MODE_VAR9 = 2'b11
	} dsu_mode_t;
	typedef struct packed {
		logic rx;
		logic tx;
		logic rx_oe;
		logic rx_out;
	} dsu_pins_t;
	typedef struct packed {
		logic t1_ovf;
		logic t2_ovf;
		logic smod;
		logic rclk_sel;
		logic tx_clock_select_sel;
	} dsu_clk_t;
endpackage

/* core/dsu_top.sv */
// Dual serial port with shared baud timers behind an AHB-Lite slave
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "dsu_map.svh"

// Function
// - Shift mode: bidirectional data, clock out, fosc/12
// - 8-bit frame: start, eight LSB first, stop
// - 8-bit receive stores stop bit as ninth
// - 9-bit frame sends tx_ninth_bit before stop
// - 9-bit receive keeps ninth, ignores stop
// - Fixed 9-bit rate fosc/32 or fosc/64
// - Variable 9-bit mode uses timer overflow rate
// - Transmitter and receiver run independently, except shift receive waits for transmit idle
// - Receive holding register buffers one byte
// - Data address: write transmit, read receive
// - Any data write starts transmission
// - Shift receive starts when RI clear, enabled
// - Async receive starts on start bit, enabled
// - Filter passes ninth-bit-one frames only
// - Filter ignored in shift mode
// - 8-bit filter needs valid stop bit
// - Port one receive clock select picks timer
// - Port one transmit clock select picks timer
// - Port two selects held in power control
// - Timer 2 overflow flag suppressed when serial
// - Serial use forces reload, blocks external trigger reload but still sets EXF2
// - TI at eighth bit end or stop start
// - RI at eighth bit end or mid stop
// - Timer 2 baud is overflow rate over sixteen
module dsu_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic p0_rx_in,
	output logic p0_rx_out,
	output logic p0_rx_oe,
	output logic p0_tx,
	input wire logic p1_rx_in,
	output logic p1_rx_out,
	output logic p1_rx_oe,
	output logic p1_tx,
	input wire logic t2_ext_trigger_pin,
	output logic t2_overflow_flag
);
	// =============================================
	// Bus slave
	logic wr_ph_q, rd_ph_q;
	logic [11:0] addr_q;
	logic [7:0] timer2_control_q, power_control_reg_q, t1rel_q;
	logic [15:0] t2rel_q;
	logic [7:0] scon0, scon1, sbuf0, sbuf1;
	logic take;
	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address phase capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ph_q <= 1'b0;
			rd_ph_q <= 1'b0;
			addr_q <= 12'h000;
		end else begin
			wr_ph_q <= take && hwrite;
			rd_ph_q <= take && !hwrite;
			addr_q <= haddr[11:0];
		end
	end

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off, input logic ph);
		hit = ph && (a == off);
	endfunction

	logic w_scon0, w_sbuf0, w_scon1, w_sbuf1, rd_sbuf0, rd_sbuf1;
	assign w_scon0 = hit(addr_q, `DSU_OFF_SCON0, wr_ph_q);
	assign w_sbuf0 = hit(addr_q, `DSU_OFF_SBUF0, wr_ph_q);
	assign w_scon1 = hit(addr_q, `DSU_OFF_SCON1, wr_ph_q);
	assign w_sbuf1 = hit(addr_q, `DSU_OFF_SBUF1, wr_ph_q);
	assign rd_sbuf0 = hit(addr_q, `DSU_OFF_SBUF0, rd_ph_q);
	assign rd_sbuf1 = hit(addr_q, `DSU_OFF_SBUF1, rd_ph_q);

	// Read mux; unmapped words read zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_ph_q) begin
			case (addr_q)
				`DSU_OFF_SCON0: hrdata = {24'h000000, scon0};
				`DSU_OFF_SBUF0: hrdata = {24'h000000, sbuf0};
				`DSU_OFF_SCON1: hrdata = {24'h000000, scon1};
				`DSU_OFF_SBUF1: hrdata = {24'h000000, sbuf1};
				`DSU_OFF_TIMER2_CONTROL: hrdata = {24'h000000, timer2_control_q};
				`DSU_OFF_POWER_CONTROL_REG: hrdata = {24'h000000, power_control_reg_q};
				`DSU_OFF_T1REL: hrdata = {24'h000000, t1rel_q};
				`DSU_OFF_T2REL: hrdata = {16'h0000, t2rel_q};
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// =============================================
	// Shared timers
	logic [3:0] mc_q;
	logic [7:0] t1_q;
	logic [15:0] t2_q;
	logic t1_ovf, t2_ovf, t2_serial, t2x_s1_q, t2x_s2_q, t2x_old_q, t2x_fall;
	assign t2_serial = timer2_control_q[`DSU_T2_RCLK] | timer2_control_q[`DSU_T2_TX_CLOCK_SELECT] |
		power_control_reg_q[`DSU_PC_PORT2_RX_CLOCK_SELECT] | power_control_reg_q[`DSU_PC_PORT2_TX_CLOCK_SELECT];
	assign t1_ovf = (mc_q == `DSU_DIV_MACHINE) && (t1_q == 8'hFF);
	// Timer 2 counts every oscillator clock while serving a port, else per machine cycle
	assign t2_ovf = timer2_control_q[`DSU_T2_TR2] && (t2_serial || mc_q == `DSU_DIV_MACHINE) && (t2_q == 16'hFFFF);
	assign t2x_fall = t2x_old_q && !t2x_s2_q;

	// Machine-cycle prescaler
	always_ff @(posedge clk or posedge rst) begin
		if (rst) mc_q <= 4'h0;
		else mc_q <= (mc_q == `DSU_DIV_MACHINE) ? 4'h0 : mc_q + 4'h1;
	end

	// Timer 1 as 8-bit auto-reload baud source
	always_ff @(posedge clk or posedge rst) begin
		if (rst) t1_q <= 8'h00;
		else if (mc_q == `DSU_DIV_MACHINE) t1_q <= t1_ovf ? t1rel_q : t1_q + 8'h01;
	end

	// External trigger pin synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			t2x_s1_q <= 1'b1;
			t2x_s2_q <= 1'b1;
			t2x_old_q <= 1'b1;
		end else begin
			t2x_s1_q <= t2_ext_trigger_pin;
			t2x_s2_q <= t2x_s1_q;
			t2x_old_q <= t2x_s2_q;
		end
	end

	// Timer 2 counter: reload on overflow under serial use or with CPRL clear; pin reload blocked under serial use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) t2_q <= 16'h0000;
		else if (t2_ovf && (t2_serial || !timer2_control_q[`DSU_T2_CPRL])) t2_q <= t2rel_q;
		else if (t2x_fall && timer2_control_q[`DSU_T2_EXEN] && !t2_serial && !timer2_control_q[`DSU_T2_CPRL]) t2_q <= t2rel_q;
		else if (timer2_control_q[`DSU_T2_TR2] && (t2_serial || mc_q == `DSU_DIV_MACHINE)) t2_q <= t2_q + 16'h0001;
	end

	// Control registers and timer 2 flags; hardware set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer2_control_q <= 8'h00;
			power_control_reg_q <= 8'h00;
			t1rel_q <= 8'h00;
			t2rel_q <= 16'h0000;
		end else begin
			if (hit(addr_q, `DSU_OFF_TIMER2_CONTROL, wr_ph_q)) timer2_control_q <= hwdata[7:0];
			if (hit(addr_q, `DSU_OFF_POWER_CONTROL_REG, wr_ph_q)) power_control_reg_q <= hwdata[7:0];
			if (hit(addr_q, `DSU_OFF_T1REL, wr_ph_q)) t1rel_q <= hwdata[7:0];
			if (hit(addr_q, `DSU_OFF_T2REL, wr_ph_q)) t2rel_q <= hwdata[15:0];
			if (t2_ovf && !t2_serial) timer2_control_q[`DSU_T2_TF2] <= 1'b1;
			if (t2x_fall && timer2_control_q[`DSU_T2_EXEN]) timer2_control_q[`DSU_T2_EXF2] <= 1'b1;
		end
	end
	assign t2_overflow_flag = timer2_control_q[`DSU_T2_TF2];

	// =============================================
	// Two identical ports
	dsu_pkg::dsu_clk_t c0, c1;
	dsu_pkg::dsu_pins_t pn0, pn1;
	assign c0 = '{t1_ovf: t1_ovf, t2_ovf: t2_ovf, smod: power_control_reg_q[`DSU_PC_SMOD],
		rclk_sel: timer2_control_q[`DSU_T2_RCLK], tx_clock_select_sel: timer2_control_q[`DSU_T2_TX_CLOCK_SELECT]};
	assign c1 = '{t1_ovf: t1_ovf, t2_ovf: t2_ovf, smod: power_control_reg_q[`DSU_PC_SMOD],
		rclk_sel: power_control_reg_q[`DSU_PC_PORT2_RX_CLOCK_SELECT], tx_clock_select_sel: power_control_reg_q[`DSU_PC_PORT2_TX_CLOCK_SELECT]};
	assign p0_rx_out = pn0.rx_out;
	assign p0_rx_oe = pn0.rx_oe;
	assign p0_tx = pn0.tx;
	assign p1_rx_out = pn1.rx_out;
	assign p1_rx_oe = pn1.rx_oe;
	assign p1_tx = pn1.tx;

	// Same module twice, no shared state but timers and the SMOD bit
	dsu_port u_port0 (
		.clk(clk), .rst(rst), .clks(c0), .rx_in(p0_rx_in), .pins(pn0),
		.w_ctl(w_scon0), .w_data(w_sbuf0), .rd_data(rd_sbuf0), .wdata(hwdata[7:0]),
		.ctl(scon0), .rdata(sbuf0)
	);
	dsu_port u_port1 (
		.clk(clk), .rst(rst), .clks(c1), .rx_in(p1_rx_in), .pins(pn1),
		.w_ctl(w_scon1), .w_data(w_sbuf1), .rd_data(rd_sbuf1), .wdata(hwdata[7:0]),
		.ctl(scon1), .rdata(sbuf1)
	);

	// No bus write pending, so only hardware could raise the flag
	property p_t2_no_tf2;
		@(posedge clk) disable iff (rst) t2_serial && !t2_overflow_flag && !wr_ph_q |=> !t2_overflow_flag;
	endproperty
	a_t2_no_tf2: assert property (p_t2_no_tf2) else $error("flag set under serial use");
	property p_t2_reload;
		@(posedge clk) disable iff (rst) t2_ovf && t2_serial |=> t2_q == $past(t2rel_q);
	endproperty
	a_t2_reload: assert property (p_t2_reload) else $error("timer 2 did not reload");
	property p_t2_pin_blocked;
		@(posedge clk) disable iff (rst) t2_serial && t2x_fall && !t2_ovf && timer2_control_q[`DSU_T2_TR2]
			|=> t2_q == $past(t2_q) + 16'h0001;
	endproperty
	a_t2_pin_blocked: assert property (p_t2_pin_blocked) else $error("pin reloaded timer 2");
endmodule

// Single serial port: control, shifters and receive buffer
module dsu_port (
	input wire logic clk,
	input wire logic rst,
	input wire dsu_pkg::dsu_clk_t clks,
	input wire logic rx_in,
	output dsu_pkg::dsu_pins_t pins,
	input wire logic w_ctl,
	input wire logic w_data,
	input wire logic rd_data,
	input wire logic [7:0] wdata,
	output logic [7:0] ctl,
	output logic [7:0] rdata
);
	typedef enum logic [1:0] {
		DSU_RX_IDLE = 2'b00,
		DSU_RX_BITS = 2'b01,
		DSU_RX_STOP = 2'b10
	} dsu_rx_st_t;
	logic [7:0] serial_control_reg_q, rbuf_q, tsh_q, rsh_q;
	logic [3:0] tcnt_q, rcnt_q, tovs_q, rovs_q, sdiv_q;
	logic [5:0] fdiv_q;
	logic tbusy_q, tx_q, r9_q, rxs1_q, rxs2_q, rxd_q, sclk_q, sclk_rx_q;
	dsu_rx_st_t rst_q;
	dsu_pkg::dsu_mode_t mode;
	logic is9, tick_fix, t_tick, r_tick, s_tick, t_bit, r_samp, start_det;
	logic set_ti, set_ri, ri_ok;
	logic rx_stop_ok;
	assign mode = dsu_pkg::dsu_mode_t'({serial_control_reg_q[`DSU_SC_MODE_HI], serial_control_reg_q[`DSU_SC_MODE_LO]});
	assign is9 = serial_control_reg_q[`DSU_SC_MODE_HI];
	assign ctl = serial_control_reg_q;
	assign rdata = rbuf_q;

	// Receive pin synchroniser, second stage onward is logic-visible
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxs1_q <= 1'b1;
			rxs2_q <= 1'b1;
			rxd_q <= 1'b1;
		end else begin
			rxs1_q <= rx_in;
			rxs2_q <= rxs1_q;
			rxd_q <= rxs2_q;
		end
	end

	// Baud prescalers: fosc/12 shift, fosc/2 or fosc/4 ticks (x16 gives /32, /64)
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdiv_q <= 4'h0;
			fdiv_q <= 6'h00;
		end else begin
			sdiv_q <= s_tick ? 4'h0 : sdiv_q + 4'h1;
			fdiv_q <= tick_fix ? 6'h00 : fdiv_q + 6'h01;
		end
	end
	assign s_tick = (sdiv_q == `DSU_DIV_SHIFT);
	// Fixed ticks at 16x bit rate
	assign tick_fix = clks.smod ? (fdiv_q[0] == 1'b1) : (fdiv_q[1:0] == 2'b11);
	// Variable ticks: timer 2 overflow at 16x, timer 1 overflow per 16x tick
	assign t_tick = (mode == dsu_pkg::DSU_MODE_FIX9) ? tick_fix :
		(clks.tx_clock_select_sel ? clks.t2_ovf : clks.t1_ovf);
	assign r_tick = (mode == dsu_pkg::DSU_MODE_FIX9) ? tick_fix :
		(clks.rclk_sel ? clks.t2_ovf : clks.t1_ovf);
	assign t_bit = t_tick && (tovs_q == `DSU_OVS_LAST);
	assign r_samp = r_tick && (rovs_q == `DSU_OVS_MID);
	// Falling edge only, so a low stop bit cannot restart the receiver
	assign start_det = (mode != dsu_pkg::DSU_MODE_SHIFT) && rst_q == DSU_RX_IDLE && rxd_q && !rxs2_q &&
		serial_control_reg_q[`DSU_SC_REN];

	// Transmitter: tcnt counts bits of frame; shift mode uses sclk phases
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tbusy_q <= 1'b0;
			tx_q <= 1'b1;
			tsh_q <= 8'h00;
			tcnt_q <= 4'h0;
			tovs_q <= 4'h0;
			sclk_q <= 1'b1;
		end else if (w_data) begin
			tbusy_q <= 1'b1;
			tsh_q <= wdata;
			tcnt_q <= 4'h0;
			tovs_q <= 4'h0;
			tx_q <= (mode == dsu_pkg::DSU_MODE_SHIFT) ? 1'b1 : 1'b0;
		end else if (tbusy_q && mode != dsu_pkg::DSU_MODE_SHIFT) begin
			if (t_tick) tovs_q <= tovs_q + 4'h1;
			if (t_bit) begin
				tcnt_q <= tcnt_q + 4'h1;
				if (tcnt_q < 4'h8) begin
					tx_q <= tsh_q[0];
					tsh_q <= {1'b0, tsh_q[7:1]};
				end else if (tcnt_q == 4'h8 && is9) tx_q <= serial_control_reg_q[`DSU_SC_TB8];
				else if (tcnt_q == (is9 ? 4'h9 : 4'h8)) tx_q <= 1'b1;
				else tbusy_q <= 1'b0;
			end
		end else if (tbusy_q && s_tick) begin
			sclk_q <= !sclk_q;
			if (!sclk_q) begin
				tsh_q <= {1'b0, tsh_q[7:1]};
				tcnt_q <= tcnt_q + 4'h1;
				if (tcnt_q == 4'h7) tbusy_q <= 1'b0;
			end
		end
	end
	assign set_ti = (mode == dsu_pkg::DSU_MODE_SHIFT) ?
		(tbusy_q && s_tick && !sclk_q && tcnt_q == 4'h7) :
		(tbusy_q && t_bit && tcnt_q == (is9 ? 4'h9 : 4'h8));

	// Receiver: independent of transmitter state, except shift-mode start waits for tbusy_q low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_q <= DSU_RX_IDLE;
			rsh_q <= 8'h00;
			rcnt_q <= 4'h0;
			rovs_q <= 4'h0;
			r9_q <= 1'b0;
		end else begin
			case (rst_q)
				DSU_RX_IDLE: begin
					rovs_q <= 4'h0;
					rcnt_q <= 4'h0;
					if (start_det) rst_q <= DSU_RX_BITS;
					else if (mode == dsu_pkg::DSU_MODE_SHIFT && serial_control_reg_q[`DSU_SC_REN] &&
						!serial_control_reg_q[`DSU_SC_RI] && !tbusy_q) begin
						rst_q <= DSU_RX_BITS;
					end
				end
				DSU_RX_BITS: begin
					if (mode == dsu_pkg::DSU_MODE_SHIFT) begin
						if (s_tick && !sclk_rx_q) begin
							rsh_q <= {rxd_q, rsh_q[7:1]};
							rcnt_q <= rcnt_q + 4'h1;
							if (rcnt_q == 4'h7) rst_q <= DSU_RX_IDLE;
						end
					end else begin
						if (r_tick) rovs_q <= rovs_q + 4'h1;
						if (r_samp) begin
							rcnt_q <= rcnt_q + 4'h1;
							if (rcnt_q == 4'h0 && rxd_q) rst_q <= DSU_RX_IDLE; // false start
							else if (rcnt_q >= 4'h1 && rcnt_q <= 4'h8) rsh_q <= {rxd_q, rsh_q[7:1]};
							else if (rcnt_q == 4'h9 && is9) r9_q <= rxd_q;
							if (rcnt_q == (is9 ? 4'h9 : 4'h8)) rst_q <= DSU_RX_STOP;
						end
					end
				end
				DSU_RX_STOP: begin
					if (r_tick) rovs_q <= rovs_q + 4'h1;
					if (r_samp) rst_q <= DSU_RX_IDLE;
				end
				default: rst_q <= DSU_RX_IDLE;
			endcase
		end
	end

	// Shift-mode receive clock phase from a private toggle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) sclk_rx_q <= 1'b1;
		else if (rst_q == DSU_RX_BITS && mode == dsu_pkg::DSU_MODE_SHIFT && s_tick) sclk_rx_q <= !sclk_rx_q;
		else if (rst_q != DSU_RX_BITS) sclk_rx_q <= 1'b1;
	end

	// Frame end and filter decision
	assign rx_stop_ok = rxd_q;
	always_comb begin
		set_ri = 1'b0;
		ri_ok = 1'b1;
		if (mode == dsu_pkg::DSU_MODE_SHIFT) begin
			set_ri = rst_q == DSU_RX_BITS && s_tick && !sclk_rx_q && rcnt_q == 4'h7;
		end else if (rst_q == DSU_RX_STOP && r_samp) begin
			if (is9) ri_ok = !serial_control_reg_q[`DSU_SC_MPF] || r9_q;
			else ri_ok = !serial_control_reg_q[`DSU_SC_MPF] || rx_stop_ok;
			set_ri = ri_ok && !serial_control_reg_q[`DSU_SC_RI];
		end
	end

	// Holding register loads only when previous byte was taken; later byte lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst) rbuf_q <= 8'h00;
		else if (set_ri) rbuf_q <= (mode == dsu_pkg::DSU_MODE_SHIFT) ? {rxd_q, rsh_q[7:1]} : rsh_q;
	end

	// Control register; hardware sets beat software clears
	always_ff @(posedge clk or posedge rst) begin
		if (rst) serial_control_reg_q <= 8'h00;
		else begin
			if (w_ctl) serial_control_reg_q <= wdata;
			if (set_ti) serial_control_reg_q[`DSU_SC_TI] <= 1'b1;
			if (set_ri) begin
				serial_control_reg_q[`DSU_SC_RI] <= 1'b1;
				if (mode != dsu_pkg::DSU_MODE_SHIFT) serial_control_reg_q[`DSU_SC_RB8] <= is9 ? r9_q : rxd_q;
			end
		end
	end

	// Pins: shift clock on tx in shift mode, data driven on rx while sending
	assign pins.tx = (mode == dsu_pkg::DSU_MODE_SHIFT) ? (tbusy_q ? sclk_q : (rst_q == DSU_RX_BITS ? sclk_rx_q : 1'b1)) : tx_q;
	assign pins.rx_oe = (mode == dsu_pkg::DSU_MODE_SHIFT) && tbusy_q;
	assign pins.rx_out = tsh_q[0];
	assign pins.rx = rxd_q;

	property p_ti_8th;
		@(posedge clk) disable iff (rst) set_ti && !w_ctl |=> serial_control_reg_q[`DSU_SC_TI];
	endproperty
	a_ti_8th: assert property (p_ti_8th) else $error("transmit flag not set");
	property p_start_low;
		@(posedge clk) disable iff (rst) w_data && mode != dsu_pkg::DSU_MODE_SHIFT |=> !pins.tx;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");
	property p_mpf9;
		@(posedge clk) disable iff (rst) is9 && serial_control_reg_q[`DSU_SC_MPF] && !r9_q |-> !set_ri;
	endproperty
	a_mpf9: assert property (p_mpf9) else $error("filtered frame raised receive flag");
	property p_mpf8;
		@(posedge clk) disable iff (rst) mode == dsu_pkg::DSU_MODE_VAR8 && serial_control_reg_q[`DSU_SC_MPF] && set_ri |-> rxd_q;
	endproperty
	a_mpf8: assert property (p_mpf8) else $error("bad stop raised receive flag");
	property p_rb8_stop;
		@(posedge clk) disable iff (rst) mode == dsu_pkg::DSU_MODE_VAR8 && set_ri |=> serial_control_reg_q[`DSU_SC_RB8] == $past(rxd_q);
	endproperty
	a_rb8_stop: assert property (p_rb8_stop) else $error("stop bit not kept as ninth bit");
	property p_rx_en;
		@(posedge clk) disable iff (rst) rst_q == DSU_RX_IDLE && !serial_control_reg_q[`DSU_SC_REN] |=> rst_q == DSU_RX_IDLE;
	endproperty
	a_rx_en: assert property (p_rx_en) else $error("receive began while disabled");
	property p_buf;
		@(posedge clk) disable iff (rst) serial_control_reg_q[`DSU_SC_RI] && !w_ctl |=> $stable(rbuf_q);
	endproperty
	a_buf: assert property (p_buf) else $error("unread byte overwritten");
	c_tx: cover property (@(posedge clk) set_ti);
	c_rx: cover property (@(posedge clk) set_ri && is9);
	c_shift: cover property (@(posedge clk) set_ri && mode == dsu_pkg::DSU_MODE_SHIFT);
endmodule

/* testbench/dsu_peer.sv */
// Serial peer model that faces one port of the dual serial port block
`timescale 1ns/10ps

// ==========================================
// Peer: sends and captures frames on one port's pins
module dsu_peer (
	input wire logic clk,
	input wire logic tx,
	input wire logic rx_out,
	output logic line
);
	// Line rests at the mark level until a frame is sent
	initial line = 1'b1;

	// Drive one frame; async bits last per clocks, shift bits follow the port's clock
	task automatic send(input logic [1:0] m, input logic [10:0] f, input int per);
		int n;
		n = (m == 2'h1) ? 10 : 11;
		if (m == 2'h0) begin
			line <= f[0];
			for (int i = 1; i <= 8; i++) begin
				@(posedge tx);
				repeat (2) @(posedge clk);
				line <= (i < 8) ? f[i] : ~f[7]; // Released data shows the inverse
			end
			repeat (per) @(posedge clk);
			line <= 1'b1;
		end else begin
			for (int i = 0; i < n; i++) begin
				line <= f[i];
				repeat (per) @(posedge clk);
			end
			line <= 1'b1;
		end
	endtask

	// Capture one frame; async mid bit, shift data mid low phase to dodge edge races
	task automatic get(input logic [1:0] m, input int per, output logic [10:0] f, output int g);
		int n;
		time t0;
		f = 11'h000;
		g = 0;
		t0 = 0;
		n = (m == 2'h1) ? 10 : 11;
		if (m == 2'h0) begin
			for (int i = 0; i < 8; i++) begin
				@(negedge tx);
				if (i == 0) t0 = $time;
				if (i == 7) g = int'($time - t0);
				repeat (3) @(posedge clk);
				f[i] = rx_out;
			end
		end else begin
			@(negedge tx);
			repeat (per / 2) @(posedge clk);
			for (int i = 0; i < n; i++) begin
				f[i] = tx;
				if (i < n - 1) repeat (per) @(posedge clk);
			end
		end
	endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the dual serial port block
`timescale 1ns/10ps
`include "dsu_map.svh"

// ==========================================
// Bench top: bus master, two peers, checks
module tb;
	logic clk, rst, hsel, hwrite, ext_pin, hreadyout, hresp, t2f;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [10:0] f, fo;
	logic [7:0] d;
	wire [1:0] rx_out, rx_oe, tx, line;
	wire [1:0] rx_in = {rx_oe[1] ? rx_out[1] : line[1], rx_oe[0] ? rx_out[0] : line[0]};
	int miscompares = 0, tests_run = 0, cyc = 0, seed = 32'h0D87, g;

	dsu_top uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .p0_rx_in(rx_in[0]), .p0_rx_out(rx_out[0]), .p0_rx_oe(rx_oe[0]), .p0_tx(tx[0]),
		.p1_rx_in(rx_in[1]), .p1_rx_out(rx_out[1]), .p1_rx_oe(rx_oe[1]), .p1_tx(tx[1]),
		.t2_ext_trigger_pin(ext_pin), .t2_overflow_flag(t2f));
	dsu_peer pr0 (.clk(clk), .tx(tx[0]), .rx_out(rx_out[0]), .line(line[0]));
	dsu_peer pr1 (.clk(clk), .tx(tx[1]), .rx_out(rx_out[1]), .line(line[1]));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Hang guard; trigger pin toggles at random to prove it cannot disturb the baud timer
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ext_pin <= 1'($random(seed));
		if (cyc == 100000) begin
			miscompares++;
			complete_run();
		end
	end

	// ==========================================
	// Checking and reporting
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One single-word transfer; each phase is held until ready is seen high
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd);
	endtask

	task automatic rd(input logic [31:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	// Control then data word, eight bytes per port
	function automatic logic [31:0] ra(input int p, input int dt);
		return 32'(p * 8 + dt * 4);
	endfunction

	function automatic logic [31:0] cv(input logic [1:0] m, input logic mpf, input logic ren, input logic tb8);
		return {24'h0, m, mpf, ren, tb8, 3'h0};
	endfunction

	// Expected wire bits, start bit in bit 0 for async frames
	function automatic logic [10:0] frame(input logic [1:0] m, input logic [7:0] dt, input logic nine, input logic stop);
		if (m == 2'h0) return {3'h0, dt};
		return (m == 2'h1) ? {1'b0, stop, dt, 1'b0} : {stop, nine, dt, 1'b0};
	endfunction

	// Expected receive flag and ninth bit; filter is blind in shift mode
	function automatic logic [1:0] rx_exp(input logic [1:0] m, input logic mpf, input logic nine, input logic stop);
		logic b;
		b = (m == 2'h1) ? stop : nine;
		return {m == 2'h0 || !mpf || b, b};
	endfunction

	// ==========================================
	// Transfer scenarios
	task automatic txc(input int p, input logic [1:0] m, input int per, input logic [7:0] dt, input logic nine);
		logic [10:0] fr;
		int gp;
		wr(ra(p, 0), cv(m, 1'b0, 1'b0, nine));
		fork
			if (p == 1) pr1.get(m, per, fr, gp);
			else pr0.get(m, per, fr, gp);
			wr(ra(p, 1), {24'h0, dt});
		join
		repeat (per) @(posedge clk);
		rd(ra(p, 0));
		chk("tx frame", {21'h0, frame(m, dt, nine, 1'b1)}, {21'h0, fr});
		chk("tx flag", 32'h1, {31'h0, v[`DSU_SC_TI]});
		if (m == 2'h0) chk("shift span", 32'hD20, 32'(gp));
		wr(ra(p, 0), 32'h0);
	endtask

	task automatic rxc(input int p, input logic [1:0] m, input logic mpf, input logic ren, input int per,
		input logic [7:0] dt, input logic nine, input logic stop);
		logic [1:0] e;
		e = ren ? rx_exp(m, mpf, nine, stop) : 2'h0;
		fork
			wr(ra(p, 0), cv(m, mpf, ren, 1'b0));
			begin
				if (m != 2'h0) repeat (4) @(posedge clk);
				if (p == 1) pr1.send(m, frame(m, dt, nine, stop), per);
				else pr0.send(m, frame(m, dt, nine, stop), per);
			end
		join
		repeat (per) @(posedge clk);
		rd(ra(p, 0));
		chk("rx flag", {31'h0, e[1]}, {31'h0, v[`DSU_SC_RI]});
		if (e[1] && m != 2'h0) chk("rx ninth", {31'h0, e[0]}, {31'h0, v[`DSU_SC_RB8]});
		rd(ra(p, 1));
		if (e[1]) chk("rx data", {24'h0, dt}, v);
		wr(ra(p, 0), 32'h0);
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		ext_pin = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wr(32'h20, 32'hFF);
		for (int i = 0; i < 9; i++) begin
			rd(32'(i * 4));
			chk("reset read", 32'h0, {v[31:1], v[0] | hresp});
		end
		chk("pins idle", 32'h3, {28'h0, rx_oe, tx});
		wr({20'h0, `DSU_OFF_T1REL}, 32'hFF);
		wr({20'h0, `DSU_OFF_T2REL}, 32'hFFFE);
		wr({20'h0, `DSU_OFF_TIMER2_CONTROL}, 32'h3C);
		txc(0, 2'h2, 64, 8'($random(seed)), 1'b1);
		rxc(0, 2'h2, 1'b0, 1'b1, 64, 8'($random(seed)), 1'b0, 1'b0);
		wr({20'h0, `DSU_OFF_POWER_CONTROL_REG}, 32'h80);
		txc(0, 2'h0, 12, 8'($random(seed)), 1'b0);
		rxc(0, 2'h0, 1'b1, 1'b1, 12, 8'($random(seed)), 1'b0, 1'b0);
		// Timer 2 starts from zero, so its first overflow is a full 16-bit count away
		wait (cyc >= 66000);
		d = 8'($random(seed));
		wr(ra(1, 0), cv(2'h1, 1'b0, 1'b1, 1'b0));
		fork
			pr1.get(2'h1, 192, fo, g);
			wr(ra(1, 1), {24'h0, d});
			begin
				repeat (4) @(posedge clk);
				pr1.send(2'h1, frame(2'h1, ~d, 1'b0, 1'b1), 192);
			end
		join
		repeat (192) @(posedge clk);
		rd(ra(1, 0));
		chk("duplex flags", 32'h7, {29'h0, v[2:0]});
		chk("duplex frame", {21'h0, frame(2'h1, d, 1'b0, 1'b1)}, {21'h0, fo});
		rd(ra(1, 1));
		chk("duplex data", {24'h0, ~d}, v);
		wr(ra(1, 0), 32'h0);
		for (int m = 1; m < 4; m++) begin
			txc(0, 2'(m), 32, 8'($random(seed)), 1'($random(seed)));
			for (int k = 0; k < 4; k++) begin
				rxc(0, 2'(m), k[1], 1'b1, 32, 8'($random(seed)), k[0], (m == 1) ? k[0] : 1'($random(seed)));
			end
		end
		rxc(0, 2'h3, 1'b0, 1'b0, 32, 8'($random(seed)), 1'b1, 1'b1);
		d = 8'($random(seed));
		wr(ra(0, 0), cv(2'h3, 1'b0, 1'b1, 1'b0));
		pr0.send(2'h3, frame(2'h3, d, 1'b1, 1'b1), 32);
		pr0.send(2'h3, frame(2'h3, ~d, 1'b0, 1'b1), 32);
		repeat (32) @(posedge clk);
		rd(ra(0, 1));
		chk("held byte", {24'h0, d}, v);
		wr(ra(0, 0), 32'h0);
		wr({20'h0, `DSU_OFF_POWER_CONTROL_REG}, 32'hB0);
		txc(1, 2'h3, 32, 8'($random(seed)), 1'b1);
		rxc(1, 2'h3, 1'b1, 1'b1, 32, 8'($random(seed)), 1'b1, 1'b0);
		wr({20'h0, `DSU_OFF_TIMER2_CONTROL}, 32'h2C);
		txc(0, 2'h3, 192, 8'($random(seed)), 1'b0);
		rxc(0, 2'h3, 1'b0, 1'b1, 32, 8'($random(seed)), 1'b0, 1'b1);
		rd({20'h0, `DSU_OFF_TIMER2_CONTROL});
		chk("t2 flag", 32'h0, {30'h0, v[`DSU_T2_TF2], t2f});
		complete_run();
	end
endmodule
